// [verilog/sss_sequencer.sv]
// Purpose: step sequencer/translator for a two-phase unipolar stepper driver
// Assumes: step, direction, resolution and logic-reset pins are asynchronous to SYS_CLK
// Notes:   registers reached over APB; one wait state on every transfer
module sss_sequencer
    import sss_pkg::*;
(
    input  wire logic        SYS_CLK,              // 200 MHz system clock
    input  wire logic        RESET,                // synchronous reset, active high
    input  wire logic        STEP,                 // step pulse pin
    input  wire logic        DIRECTION_SELECT,     // direction pin, low = forward
    input  wire logic        RESOLUTION_SELECT_0,  // resolution select bit 0
    input  wire logic        RESOLUTION_SELECT_1,  // resolution select bit 1
    input  wire logic        RESOLUTION_SELECT_2,  // resolution select bit 2
    input  wire logic        LOGIC_RESET,          // asynchronous sequencer reset pin
    input  wire logic        PSEL,                 // apb select
    input  wire logic        PENABLE,              // apb enable
    input  wire logic        PWRITE,               // apb direction
    input  wire logic [7:0]  PADDR,                // apb byte address
    input  wire logic [31:0] PWDATA,               // apb write data
    output logic      [31:0] PRDATA,               // apb read data
    output logic             PREADY,               // apb ready
    output logic             PSLVERR,              // apb error on unmapped address
    output logic      [3:0]  PHASE_A_CODE,         // phase A ratio code, 0 = off
    output logic             PHASE_A_NEG,          // phase A polarity, high = /A
    output logic      [3:0]  PHASE_B_CODE,         // phase B ratio code, 0 = off
    output logic             PHASE_B_NEG,          // phase B polarity, high = /B
    output logic             HOLD_STANDBY          // hold standby state selected
);
    import sss_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    sss_pins_s raw_pins;
    sss_pins_s pins;
    logic      step_prev;
    logic      rst_meta;
    logic      seq_reset;

    assign raw_pins.step = STEP;
    assign raw_pins.dir  = DIRECTION_SELECT;
    assign raw_pins.res  = {RESOLUTION_SELECT_2, RESOLUTION_SELECT_1, RESOLUTION_SELECT_0};

    sss_sync #(
        .WIDTH ($bits(sss_pins_s))
    ) u_pin_sync (
        .clk (SYS_CLK),
        .rst (RESET),
        .d   (raw_pins),
        .q   (pins)
    );

    always_ff @(posedge SYS_CLK or posedge LOGIC_RESET) begin
        if (LOGIC_RESET) begin
            rst_meta  <= 1'b1;
            seq_reset <= 1'b1;
        end else begin
            rst_meta  <= 1'b0;
            seq_reset <= rst_meta;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            step_prev <= 1'b0;
        end else begin
            step_prev <= pins.step;
        end
    end

    // ------------------------------------------------------------------
    // step decoding
    // ------------------------------------------------------------------
    // mask of low position bits that a resolution never visits
    function automatic logic [5:0] step_mask(input sss_mode_e m);
        logic [5:0] r;
        r = 6'h00;
        case (m)
            SSS_FULL_MID,
            SSS_FULL_MAX:  r = 6'h0f;
            SSS_HALF,
            SSS_HALF_MAX:  r = 6'h07;
            SSS_QUARTER:   r = 6'h03;
            SSS_EIGHTH:    r = 6'h01;
            SSS_SIXTEENTH: r = 6'h00;
            default:       r = 6'h00;
        endcase
        return r;
    endfunction

    logic [SSS_POS_W-1:0] pos;
    sss_mode_e            cur_mode;
    logic                 cur_dir;
    logic                 run_enable;
    logic                 soft_reset;
    logic [31:0]          steps_taken;
    logic [31:0]          steps_ignored;

    wire logic       step_rise   = pins.step & ~step_prev;
    wire sss_mode_e  new_mode    = sss_mode_e'(pins.res);
    wire logic       new_dir     = pins.dir;
    wire logic       new_hold    = (new_mode == SSS_HOLD);
    // steps inside a logic reset are lost, so they count as refused
    wire logic       advance     = step_rise & run_enable & ~new_hold & ~seq_reset;
    wire logic       refused     = step_rise & ~advance;
    wire logic [5:0] new_mask    = step_mask(new_mode);
    // round from current grid onto new grid
    // result lands on the new grid
    wire logic [5:0] fwd_pos     = 6'((pos | new_mask) + SSS_POS_ONE);
    wire logic [5:0] rev_pos     = 6'(pos - SSS_POS_ONE) & ~new_mask;
    wire logic [5:0] next_pos    = new_dir ? rev_pos : fwd_pos;

    always_ff @(posedge SYS_CLK or posedge seq_reset) begin
        if (seq_reset) begin
            pos <= SSS_START_POS;
        end else if (RESET || soft_reset) begin
            pos <= SSS_START_POS;
        end else if (advance) begin
            pos <= next_pos;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cur_mode <= SSS_FULL_MID;
            cur_dir  <= 1'b0;
        end else if (step_rise) begin
            cur_mode <= new_mode;
            cur_dir  <= new_dir;
        end
    end

    // ------------------------------------------------------------------
    // phase outputs
    // ------------------------------------------------------------------
    sss_coils_s coils;

    sss_phase_map u_phase_map (
        .pos   (pos),
        .mode  (cur_mode),
        .coils (coils)
    );

    // outputs lag the position by one clock so that they stay flop-driven
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            PHASE_A_CODE <= SSS_CODE_MID;
            PHASE_A_NEG  <= 1'b0;
            PHASE_B_CODE <= SSS_CODE_MID;
            PHASE_B_NEG  <= 1'b0;
            HOLD_STANDBY <= 1'b0;
        end else begin
            PHASE_A_CODE <= coils.a.code;
            PHASE_A_NEG  <= coils.a.neg;
            PHASE_B_CODE <= coils.b.code;
            PHASE_B_NEG  <= coils.b.neg;
            HOLD_STANDBY <= (cur_mode == SSS_HOLD);
        end
    end

    // ------------------------------------------------------------------
    // step counters
    // ------------------------------------------------------------------
    // counters wrap silently; software reads them as free-running totals
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            steps_taken   <= 32'h0000_0000;
            steps_ignored <= 32'h0000_0000;
        end else begin
            if (advance) begin
                steps_taken <= steps_taken + 32'h0000_0001;
            end
            if (refused) begin
                steps_ignored <= steps_ignored + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    wire logic access    = PSEL & PENABLE;
    wire logic first_acc = access & ~PREADY;
    wire logic hit_ctrl  = (PADDR == SSS_OFS_CTRL);
    wire logic hit_stat  = (PADDR == SSS_OFS_STATUS);
    wire logic hit_phase = (PADDR == SSS_OFS_PHASE);
    wire logic hit_steps = (PADDR == SSS_OFS_STEPS);
    wire logic hit_ign   = (PADDR == SSS_OFS_IGNORED);
    wire logic hit_any   = hit_ctrl | hit_stat | hit_phase | hit_steps | hit_ign;
    // a write lands only on the edge where the master sees pready high
    wire logic wr_ctrl   = access & PREADY & PWRITE & hit_ctrl;

    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] phase_word;
    logic [31:0] rd_mux;

    always_comb begin
        ctrl_word                   = 32'h0000_0000;
        ctrl_word[SSS_CTRL_RUN_BIT] = run_enable;
    end

    always_comb begin
        stat_word                                   = 32'h0000_0000;
        stat_word[SSS_ST_POS_LSB +: SSS_POS_W]      = pos;
        stat_word[SSS_ST_MODE_LSB +: $bits(sss_mode_e)] = cur_mode;
        stat_word[SSS_ST_DIR_BIT]                   = cur_dir;
        stat_word[SSS_ST_HOLD_BIT]                  = (cur_mode == SSS_HOLD);
    end

    always_comb begin
        phase_word                                      = 32'h0000_0000;
        phase_word[SSS_PH_A_LSB +: $bits(sss_drive_s)]  = coils.a;
        phase_word[SSS_PH_B_LSB +: $bits(sss_drive_s)]  = coils.b;
    end

    assign rd_mux = hit_ctrl  ? ctrl_word     :
                    hit_stat  ? stat_word     :
                    hit_phase ? phase_word    :
                    hit_steps ? steps_taken   :
                    hit_ign   ? steps_ignored : 32'h0000_0000;

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= first_acc;
            PSLVERR <= first_acc & ~hit_any;
            PRDATA  <= (first_acc & ~PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // soft reset bit self-clears; run enable gates accepted steps
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            run_enable <= SSS_CTRL_RUN_RESET;
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= wr_ctrl & PWDATA[SSS_CTRL_SOFT_BIT];
            if (wr_ctrl) begin
                run_enable <= PWDATA[SSS_CTRL_RUN_BIT];
            end
        end
    end

endmodule

// [verilog/sss_pkg.sv]
// Purpose: shared constants, types and register map of the step sequencer
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   mode codes are {resolution_select_2, resolution_select_1, resolution_select_0}
package sss_pkg;

    // register byte offsets
    localparam logic [7:0] SSS_OFS_CTRL    = 8'h00;
    localparam logic [7:0] SSS_OFS_STATUS  = 8'h04;
    localparam logic [7:0] SSS_OFS_PHASE   = 8'h08;
    localparam logic [7:0] SSS_OFS_STEPS   = 8'h0c;
    localparam logic [7:0] SSS_OFS_IGNORED = 8'h10;

    // control register fields
    localparam int         SSS_CTRL_RUN_BIT   = 0;
    localparam int         SSS_CTRL_SOFT_BIT  = 1;
    localparam logic       SSS_CTRL_RUN_RESET = 1'b1;

    // status register fields
    localparam int         SSS_ST_POS_LSB  = 0;
    localparam int         SSS_ST_MODE_LSB = 8;
    localparam int         SSS_ST_DIR_BIT  = 12;
    localparam int         SSS_ST_HOLD_BIT = 16;

    // phase register fields
    localparam int         SSS_PH_A_LSB = 0;
    localparam int         SSS_PH_B_LSB = 8;

    // sequencer geometry
    localparam int         SSS_POS_W       = 6;
    localparam logic [5:0] SSS_START_POS   = 6'h00;
    localparam logic [5:0] SSS_QUARTER_OFS = 6'h08;
    localparam logic [5:0] SSS_POS_ONE     = 6'h01;
    localparam logic [4:0] SSS_PEAK_T      = 5'h10;
    localparam logic [3:0] SSS_CODE_MID    = 4'h8;
    localparam logic [3:0] SSS_CODE_FULL   = 4'hf;

    typedef enum logic [2:0] {
        SSS_FULL_MID  = 3'h0,
        SSS_FULL_MAX  = 3'h1,
        SSS_HALF      = 3'h2,
        SSS_HALF_MAX  = 3'h3,
        SSS_QUARTER   = 3'h4,
        SSS_EIGHTH    = 3'h5,
        SSS_SIXTEENTH = 3'h6,
        SSS_HOLD      = 3'h7
    } sss_mode_e;

    typedef struct packed {
        logic       neg;
        logic [3:0] code;
    } sss_drive_s;

    typedef struct packed {
        sss_drive_s a;
        sss_drive_s b;
    } sss_coils_s;

    typedef struct packed {
        logic       step;
        logic       dir;
        logic [2:0] res;
    } sss_pins_s;

endpackage

// [verilog/sss_sync.sv]
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are asynchronous to SYS_CLK
// Notes:   first stage is read only by the second stage
module sss_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             clk,    // system clock
    input  wire logic             rst,    // synchronous reset
    input  wire logic [WIDTH-1:0] d,      // raw pin levels
    output logic      [WIDTH-1:0] q       // synchronised levels
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// [verilog/sss_phase_map.sv]
// Purpose: maps a table position to per-phase ratio codes and polarity
// Assumes: position 0 is both phases positive at the mid code
// Notes:   purely combinational
module sss_phase_map
    import sss_pkg::*;
(
    input  wire logic [5:0]        pos,    // table position
    input  sss_pkg::sss_mode_e     mode,   // active resolution
    output sss_pkg::sss_coils_s    coils   // phase drive codes
);
    // one shape serves both phases, offset by a quarter of the table
    function automatic sss_drive_s shape(input logic [5:0] t);
        sss_drive_s r;
        r.neg = t[5];
        if (t[4:0] == SSS_PEAK_T) begin
            r.code = SSS_CODE_FULL;
        end else if (t[4]) begin
            r.code = 4'((~t[4:0]) + 5'h01);
        end else begin
            r.code = t[3:0];
        end
        return r;
    endfunction

    wire logic       max_mode = (mode == SSS_FULL_MAX) || (mode == SSS_HALF_MAX);
    wire sss_drive_s raw_a    = shape(6'(SSS_QUARTER_OFS - pos));
    wire sss_drive_s raw_b    = shape(6'(pos + SSS_QUARTER_OFS));

    assign coils.a.code = (max_mode && raw_a.code == SSS_CODE_MID) ? SSS_CODE_FULL : raw_a.code;
    assign coils.b.code = (max_mode && raw_b.code == SSS_CODE_MID) ? SSS_CODE_FULL : raw_b.code;
    assign coils.a.neg  = raw_a.neg;
    assign coils.b.neg  = raw_b.neg;
endmodule

// [testbench/sss_sequencer_chk.sv]
// Purpose: port assertions for the step sequencer
// Assumes: mode pins stay put for some cycles around each step
// Notes:   watches only design outputs against the pins
module sss_sequencer_chk
    import sss_pkg::*;
(
    input wire logic       SYS_CLK,             // clock
    input wire logic       RESET,               // sync reset
    input wire logic       RESOLUTION_SELECT_0, // mode pin 0
    input wire logic       RESOLUTION_SELECT_1, // mode pin 1
    input wire logic       RESOLUTION_SELECT_2, // mode pin 2
    input wire logic       LOGIC_RESET,         // sequencer reset pin
    input wire logic       PSEL,                // apb select
    input wire logic       PENABLE,             // apb enable
    input wire logic       PREADY,              // apb ready
    input wire logic [3:0] PHASE_A_CODE,        // phase a code
    input wire logic       PHASE_A_NEG,         // phase a polarity
    input wire logic [3:0] PHASE_B_CODE,        // phase b code
    input wire logic       PHASE_B_NEG,         // phase b polarity
    input wire logic       HOLD_STANDBY         // hold state
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [2:0] res = {RESOLUTION_SELECT_2, RESOLUTION_SELECT_1, RESOLUTION_SELECT_0};
    wire logic [3:0] a   = PHASE_A_CODE;
    wire logic [3:0] b   = PHASE_B_CODE;
    wire logic [4:0] sum = {1'b0, a} + {1'b0, b};
    wire logic [9:0] ph  = {PHASE_A_NEG, a, PHASE_B_NEG, b};
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    sequence lreset_held;
        LOGIC_RESET [*2];
    endsequence
    // hold flag and phase outputs change on the same edge, so wait four hold samples before comparing
    sequence hold_quiet;
        (HOLD_STANDBY && !LOGIC_RESET) [*4];
    endsequence
    a_lreset_home:
        assert property (lreset_held |=> a == b && !PHASE_A_NEG && !PHASE_B_NEG)
        else $error("phases not home under logic reset");
    a_hold_still:
        assert property (hold_quiet |-> $stable(ph))
        else $error("phases moved in hold state");
    a_codes_pair:
        assert property (!HOLD_STANDBY [*3] |-> sum == 5'h10 || sum == 5'h0f || sum == 5'h1e)
        else $error("phase code pair off the table");
    a_quarter_grid:
        assert property ($changed(ph) && res == 3'h4
            |-> (a[1:0] == 2'h0 || a == 4'hf) && (b[1:0] == 2'h0 || b == 4'hf))
        else $error("quarter step left its grid");
    a_eighth_grid:
        assert property ($changed(ph) && res == 3'h5
            |-> (!a[0] || a == 4'hf) && (!b[0] || b == 4'hf))
        else $error("eighth step left its grid");
    a_full_mid:
        assert property ($changed(ph) && res == 3'h0 |-> a == SSS_CODE_MID && b == SSS_CODE_MID)
        else $error("full step not at mid code");
    a_max_fixed:
        assert property ($changed(ph) && !res[2] && res[0]
            |-> (a == 4'h0 || a == SSS_CODE_FULL) && (b == 4'h0 || b == SSS_CODE_FULL))
        else $error("fixed full ratio not applied");
    a_apb_ready:
        assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("apb ready not a single wait state");
endmodule

// [testbench/sss_ctl_model.sv]
// Purpose: controller model issuing step commands
// Assumes: called from one bench process at a time
// Notes:   step idles low; gap before each edge varies, but is fixed after a hold step
module sss_ctl_model (
    input  wire logic       clk,  // bench clock
    output logic            step, // step pin
    output logic            dir,  // direction pin
    output logic [2:0]      res   // resolution pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic was_hold = 1'b0;
    initial begin
        step = 1'b0;
        dir  = 1'b0;
        res  = 3'h0;
    end
    task automatic pulse(input logic d, input logic [2:0] r, input logic fire);
        @(posedge clk);
        dir <= d;
        res <= r;
        repeat (was_hold ? 12 : 3 + $urandom % 4) @(posedge clk);
        step <= fire;
        repeat (4) @(posedge clk);
        step <= 1'b0;
        repeat (8) @(posedge clk);
        was_hold = fire && r == 3'h7;
    endtask
endmodule

// [testbench/sss_sequencer_tb.sv]
// Purpose: self-checking bench for the step sequencer
// Assumes: one wait state apb slave, pins synchronised inside
// Notes:   position model walks the same 64-entry table
module sss_sequencer_tb
    import sss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        SYS_CLK;
    logic        RESET = 1'b1;
    logic        LOGIC_RESET = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic [3:0]  PHASE_A_CODE;
    logic        PHASE_A_NEG;
    logic [3:0]  PHASE_B_CODE;
    logic        PHASE_B_NEG;
    logic        HOLD_STANDBY;
    logic        STEP;
    logic        DIRECTION_SELECT;
    logic [2:0]  res;
    logic [31:0] rd;
    logic        err;
    int          fails = 0;
    int          checks_done = 0;
    int          pos = 0;
    int          mode = 0;
    int          ldir = 0;
    int          taken = 0;
    int          ign = 0;
    int          run = 1;
    int          masks[8] = '{15, 15, 7, 7, 3, 1, 0, 0};
    sss_coils_s  ex;
    sss_sequencer DUT (
        .SYS_CLK(SYS_CLK), .RESET(RESET), .STEP(STEP), .DIRECTION_SELECT(DIRECTION_SELECT),
        .RESOLUTION_SELECT_0(res[0]), .RESOLUTION_SELECT_1(res[1]),
        .RESOLUTION_SELECT_2(res[2]), .LOGIC_RESET(LOGIC_RESET), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PHASE_A_CODE(PHASE_A_CODE),
        .PHASE_A_NEG(PHASE_A_NEG), .PHASE_B_CODE(PHASE_B_CODE), .PHASE_B_NEG(PHASE_B_NEG),
        .HOLD_STANDBY(HOLD_STANDBY)
    );
    sss_ctl_model ctl (.clk(SYS_CLK), .step(STEP), .dir(DIRECTION_SELECT), .res(res));
    initial begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do
            @(posedge SYS_CLK);
        while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    function automatic logic [3:0] fall(int t);
        return 4'(t < 8 ? 8 - t : t == 8 ? 0 : t - 8);
    endfunction
    function automatic logic [3:0] rise(int t);
        return 4'(t < 8 ? 8 + t : t == 8 ? 15 : 24 - t);
    endfunction
    function automatic sss_coils_s model_ph(int p, int m);
        int q = p / 16;
        int t = p % 16;
        sss_coils_s e;
        e.a.code = q % 2 ? rise(t) : fall(t);
        e.b.code = q % 2 ? fall(t) : rise(t);
        e.a.neg = (q == 1 || q == 0 && t > 8 || q == 2 && t < 8) && e.a.code != 0;
        e.b.neg = (q == 2 || q == 1 && t > 8 || q == 3 && t < 8) && e.b.code != 0;
        if (m == 1 || m == 3) begin
            e.a.code = e.a.code == 8 ? 4'hf : e.a.code;
            e.b.code = e.b.code == 8 ? 4'hf : e.b.code;
        end
        return e;
    endfunction
    task automatic check_ph();
        sss_coils_s s;
        s = {PHASE_A_NEG & |PHASE_A_CODE, PHASE_A_CODE, PHASE_B_NEG & |PHASE_B_CODE, PHASE_B_CODE};
        check(s, model_ph(pos, mode));
    endtask
    task automatic move(input logic d, input int m);
        ctl.pulse(d, m[2:0], 1'b1);
        mode = m;
        ldir = d;
        if (m == 7 || run == 0)
            ign++;
        else begin
            taken++;
            pos = d ? (pos - 1) & ~masks[m] & 63 : ((pos | masks[m]) + 1) & 63;
        end
        check(HOLD_STANDBY, m == 7);
        if (m != 7)
            check_ph();
    endtask
    // about 320 steps of under 30 cycles each, with a wide margin
    initial begin
        #200us;
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(88));
        repeat (16) @(posedge SYS_CLK);
        RESET <= 1'b0;
        repeat (4) @(posedge SYS_CLK);
        apb(1'b0, SSS_OFS_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000);
        for (int m = 0; m < 8; m++) begin
            move(1'b0, m);
            move(1'b1, m);
        end
        ctl.pulse(1'b1, 3'h6, 1'b0);
        check_ph();
        check(HOLD_STANDBY, mode == 7);
        repeat (300) move(1'($urandom), $urandom % 8);
        apb(1'b1, SSS_OFS_CTRL, 32'h0);
        run = 0;
        move(1'b0, 4);
        apb(1'b1, SSS_OFS_CTRL, 32'h1);
        run = 1;
        apb(1'b0, SSS_OFS_STEPS, 32'h0);
        check(rd, taken);
        apb(1'b0, SSS_OFS_IGNORED, 32'h0);
        check(rd, ign);
        // soft reset returns the position to the start
        apb(1'b1, SSS_OFS_CTRL, 32'h3);
        pos = 0;
        apb(1'b0, SSS_OFS_STATUS, 32'h0);
        check(rd, (mode << 8) + (ldir << 12));
        check_ph();
        move(1'b0, 0);
        LOGIC_RESET <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        LOGIC_RESET <= 1'b0;
        repeat (8) @(posedge SYS_CLK);
        pos = 0;
        check_ph();
        move(1'b1, 2);
        apb(1'b0, SSS_OFS_STATUS, 32'h0);
        check(rd, pos + (mode << 8) + (ldir << 12));
        apb(1'b0, SSS_OFS_PHASE, 32'h0);
        ex = model_ph(pos, mode);
        check({err, rd[30:0]}, {19'h0, ex.b, 3'h0, ex.a});
        give_verdict();
    end
endmodule
bind sss_sequencer sss_sequencer_chk u_chk (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .RESOLUTION_SELECT_0(RESOLUTION_SELECT_0),
    .RESOLUTION_SELECT_1(RESOLUTION_SELECT_1), .RESOLUTION_SELECT_2(RESOLUTION_SELECT_2),
    .LOGIC_RESET(LOGIC_RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .PHASE_A_CODE(PHASE_A_CODE), .PHASE_A_NEG(PHASE_A_NEG), .PHASE_B_CODE(PHASE_B_CODE),
    .PHASE_B_NEG(PHASE_B_NEG), .HOLD_STANDBY(HOLD_STANDBY)
);
